/* hw/fdisp_pkg.sv */
// Purpose: shared constants and types of the two-wire flash driver port
// Assumes: one 50 MHz system clock on both ends
// Notes:   bus rates are least bit periods, rounded up to whole cycles
package fdisp_pkg;
  localparam logic [6:0] SLAVE_ADDR   = 7'h33;
  localparam logic [4:0] MCODE_PREFIX = 5'h01;
  localparam logic [2:0] MCODE_LOW    = 3'h0;
  localparam logic [7:0] NO_REG_DATA  = 8'h00;
  localparam logic [1:0] LINES_IDLE   = 2'h3;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_LAST_TX  = 4'h7;
  localparam logic [1:0] PH_ADDR      = 2'h0;
  localparam logic [1:0] PH_REG       = 2'h1;
  localparam logic [1:0] PH_DATA      = 2'h2;

  localparam int CLK_KHZ      = 50000;
  localparam int STD_RATE_KBPS = 100;
  localparam int FS_RATE_KBPS = 400;
  localparam int HS_RATE_KBPS = 3400;
  // quarter of a bit period, least time so rounded up
  localparam int FS_QTR_INT = (CLK_KHZ + 4 * FS_RATE_KBPS - 1) /
                              (4 * FS_RATE_KBPS);
  localparam int HS_QTR_INT = (CLK_KHZ + 4 * HS_RATE_KBPS - 1) /
                              (4 * HS_RATE_KBPS);
  localparam logic [5:0] FS_QTR_CYC = 6'(FS_QTR_INT);
  localparam logic [5:0] HS_QTR_CYC = 6'(HS_QTR_INT);

  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;

  // host sequence positions
  localparam logic [3:0] STEP_HS_FIRST = 4'h0;
  localparam logic [3:0] STEP_LS_FIRST = 4'h2;
  localparam logic [3:0] STEP_HS_FROM  = 4'h3;
  localparam logic [3:0] STEP_STOP     = 4'h8;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_RX   = 3'b001,
    DEV_ACK  = 3'b011,
    DEV_TX   = 3'b010,
    DEV_RACK = 3'b110
  } fdisp_dev_e;

  typedef enum logic {
    HOST_IDLE = 1'b0,
    HOST_RUN  = 1'b1
  } fdisp_host_e;

  typedef enum logic [1:0] {
    K_START = 2'b00,
    K_WR    = 2'b01,
    K_RD    = 2'b11,
    K_STOP  = 2'b10
  } fdisp_kind_e;
endpackage

/* hw/fdisp_if.sv */
// Purpose: two-wire bus joining the host end and the device end
// Assumes: both lines pulled up; any enabled low drive wins
// Notes:   design ends never see a floating value, only the wired level
`timescale 1ns/1ps
interface fdisp_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_scl_o;
  logic d_scl_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  assign scl = !((h_scl_oe && !h_scl_o) || (d_scl_oe && !d_scl_o));
  assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

  modport host (
    output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
    input  scl, sda
  );
  modport dev (
    output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe,
    input  scl, sda
  );
endinterface

/* hw/fdisp_dev.sv */
// Purpose: device end of the two-wire port, register write stream out
// Assumes: bus master generates every clock edge and all conditions
// Notes:   write stream passes a small fifo; a full fifo refuses the byte
//
// Behaviour
// - slave only; standard, fast, high-speed rates
// - standard and fast share one protocol
// - 7-bit only; 10-bit, general call unanswered
// - answer only address 0110011
// - start is data falling, clock high
// - master makes clock, addresses, conditions
// - seven address bits, direction bit, msb first
// - data changes only while clock low
// - matched address acked through ninth clock
// - receiver acknowledges every data byte the fifo has room for
// - nine-clock units repeat until master ends
// - lines only pulled low or released
// - master code unacked; high speed after restart
// - stop returns to low-speed settings
// - write stored at falling edge ending ack
// - unimplemented registers read back as 00h
`timescale 1ns/1ps
module fdisp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  logic             clk_sys_i,
  input  logic             rst_i,
  input  logic             in_valid_i,
  output logic             in_ready_o,
  input  logic [WIDTH-1:0] in_data_i,
  output logic             out_valid_o,
  input  logic             out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wp_q != rp_q;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

module fdisp_dev (
  input  logic       clk_sys_i,
  input  logic       rst_i,
  fdisp_if.dev       bus,
  output logic       wr_valid_o,
  input  logic       wr_ready_i,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_addr_o,
  input  logic [7:0] rd_data_i,
  input  logic       rd_hit_i,
  output logic       hs_mode_o
);
  // bit 0 is the clock line, bit 1 the data line
  logic [1:0]         s1_q;
  logic [1:0]         s2_q;
  logic [1:0]         s3_q;
  logic [1:0]         f_q;
  logic [1:0]         fp_q;
  logic [1:0]         f_d;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_seen;
  logic               stop_seen;
  fdisp_pkg::fdisp_dev_e state_q;
  logic [3:0]         cnt_q;
  logic [7:0]         sh_q;
  logic [1:0]         phase_q;
  logic               rw_q;
  logic               hs_q;
  logic               hs_pend_q;
  logic               mack_q;
  logic [7:0]         reg_q;
  logic               sda_oe_q;
  logic               fifo_ready;
  logic               push;
  logic [7:0]         rd_byte;

  // the device never drives a line high and never touches the clock
  assign bus.d_scl_o  = 1'b0;
  assign bus.d_scl_oe = 1'b0;
  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = sda_oe_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_q <= fdisp_pkg::LINES_IDLE;
      s2_q <= fdisp_pkg::LINES_IDLE;
      s3_q <= fdisp_pkg::LINES_IDLE;
    end else begin
      s1_q <= {bus.sda, bus.scl};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level counts only once the second and third stages agree
  assign f_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & f_q);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      f_q  <= fdisp_pkg::LINES_IDLE;
      fp_q <= fdisp_pkg::LINES_IDLE;
    end else begin
      f_q  <= f_d;
      fp_q <= f_q;
    end
  end

  assign scl_rise   = f_q[0] && !fp_q[0];
  assign scl_fall   = !f_q[0] && fp_q[0];
  assign start_seen = fp_q[1] && !f_q[1] && f_q[0] && fp_q[0];
  assign stop_seen  = !fp_q[1] && f_q[1] && f_q[0] && fp_q[0];
  assign rd_byte    = rd_hit_i ? rd_data_i : fdisp_pkg::NO_REG_DATA;
  // write lands as the clock falls at the end of the data ack
  assign push = (state_q == fdisp_pkg::DEV_ACK) && scl_fall &&
                (phase_q == fdisp_pkg::PH_DATA) && !rw_q;

  // one protocol for every rate: timing only comes from the master clock
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q   <= fdisp_pkg::DEV_IDLE;
      cnt_q     <= '0;
      sh_q      <= '0;
      phase_q   <= fdisp_pkg::PH_ADDR;
      rw_q      <= 1'b0;
      hs_q      <= 1'b0;
      hs_pend_q <= 1'b0;
      mack_q    <= 1'b0;
      reg_q     <= '0;
    end else if (start_seen) begin
      state_q   <= fdisp_pkg::DEV_RX;
      cnt_q     <= '0;
      phase_q   <= fdisp_pkg::PH_ADDR;
      hs_q      <= hs_q || hs_pend_q;
      hs_pend_q <= 1'b0;
    end else if (stop_seen) begin
      state_q   <= fdisp_pkg::DEV_IDLE;
      hs_q      <= 1'b0;
      hs_pend_q <= 1'b0;
    end else begin
      unique case (state_q)
        fdisp_pkg::DEV_IDLE: begin
        end
        fdisp_pkg::DEV_RX: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], f_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == fdisp_pkg::BIT_ACK) begin
            cnt_q <= '0;
            unique case (phase_q)
              fdisp_pkg::PH_ADDR: begin
                // general call and 10-bit prefixes never equal our address
                if (sh_q[7:1] == fdisp_pkg::SLAVE_ADDR) begin
                  state_q <= fdisp_pkg::DEV_ACK;
                  rw_q    <= sh_q[0];
                end else begin
                  state_q <= fdisp_pkg::DEV_IDLE;
                  if (sh_q[7:3] == fdisp_pkg::MCODE_PREFIX) begin
                    hs_pend_q <= 1'b1;
                  end
                end
              end
              fdisp_pkg::PH_REG: begin
                reg_q   <= sh_q;
                state_q <= fdisp_pkg::DEV_ACK;
              end
              default: begin
                // no room for the byte: refuse it rather than lose it
                state_q <= fifo_ready ? fdisp_pkg::DEV_ACK
                                      : fdisp_pkg::DEV_IDLE;
              end
            endcase
          end
        end
        fdisp_pkg::DEV_ACK: begin
          if (scl_fall) begin
            if (phase_q == fdisp_pkg::PH_ADDR && rw_q) begin
              state_q <= fdisp_pkg::DEV_TX;
              sh_q    <= rd_byte;
              reg_q   <= reg_q + 8'h01;
              phase_q <= fdisp_pkg::PH_DATA;
            end else begin
              state_q <= fdisp_pkg::DEV_RX;
              if (phase_q == fdisp_pkg::PH_DATA) begin
                reg_q <= reg_q + 8'h01;
              end else begin
                phase_q <= phase_q + 2'h1;
              end
            end
          end
        end
        fdisp_pkg::DEV_TX: begin
          if (scl_fall) begin
            sh_q  <= {sh_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == fdisp_pkg::BIT_LAST_TX) begin
              state_q <= fdisp_pkg::DEV_RACK;
              cnt_q   <= '0;
            end
          end
        end
        fdisp_pkg::DEV_RACK: begin
          if (scl_rise) begin
            mack_q <= !f_q[1];
          end else if (scl_fall) begin
            if (mack_q) begin
              state_q <= fdisp_pkg::DEV_TX;
              sh_q    <= rd_byte;
              reg_q   <= reg_q + 8'h01;
            end else begin
              state_q <= fdisp_pkg::DEV_IDLE;
            end
          end
        end
        default: begin
          state_q <= fdisp_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // registered so the data line moves a few cycles after the clock falls
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (state_q == fdisp_pkg::DEV_ACK) ||
                  (state_q == fdisp_pkg::DEV_TX && !sh_q[7]);
    end
  end

  assign rd_addr_o = reg_q;
  assign hs_mode_o = hs_q;

  fdisp_fifo #(
    .WIDTH (fdisp_pkg::FIFO_WIDTH),
    .DEPTH (fdisp_pkg::FIFO_DEPTH)
  ) i_fdisp_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({reg_q, sh_q}),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  ({wr_addr_o, wr_data_o})
  );
endmodule

/* hw/fdisp_host.sv */
// Purpose: bus master end: single register write or read per command
// Assumes: no clock stretching by the device, so the clock runs open loop
// Notes:   high speed is entered per command and left by its own stop
`timescale 1ns/1ps
module fdisp_host (
  input  logic       clk_sys_i,
  input  logic       rst_i,
  fdisp_if.host      bus,
  input  logic       cmd_valid_i,
  output logic       cmd_ready_o,
  input  logic       cmd_rd_i,
  input  logic       cmd_hs_i,
  input  logic [7:0] cmd_reg_i,
  input  logic [7:0] cmd_data_i,
  output logic       rsp_valid_o,
  output logic       rsp_ack_o,
  output logic [7:0] rsp_data_o,
  output logic       hs_mode_o
);
  fdisp_pkg::fdisp_host_e state_q;
  fdisp_pkg::fdisp_kind_e kind;
  logic [7:0] byte_c;
  logic [3:0] idx_q;
  logic [3:0] bit_q;
  logic [1:0] qtr_q;
  logic [5:0] div_q;
  logic       tick;
  logic       rd_q;
  logic       hs_q;
  logic       fast_q;
  logic [7:0] reg_q;
  logic [7:0] dat_q;
  logic [7:0] sh_q;
  logic       ack_q;
  logic       ok_q;
  logic       scl_c;
  logic       sda_c;
  logic       scl_q;
  logic       sda_q;
  logic       rsp_q;
  logic       sy1_q;
  logic       sy2_q;
  logic       sy3_q;
  logic       sf_q;

  // open-drain: enable means pulling low, a one is a released line
  assign bus.h_scl_o  = 1'b0;
  assign bus.h_sda_o  = 1'b0;
  assign bus.h_scl_oe = !scl_q;
  assign bus.h_sda_oe = !sda_q;
  assign cmd_ready_o  = state_q == fdisp_pkg::HOST_IDLE;
  assign rsp_valid_o  = rsp_q;
  assign rsp_ack_o    = ok_q;
  assign hs_mode_o    = fast_q;
  assign tick         = div_q == 6'h00;

  always_comb begin
    kind   = fdisp_pkg::K_STOP;
    byte_c = 8'h00;
    unique case (idx_q)
      4'h0: kind = fdisp_pkg::K_START;
      4'h1: begin
        kind   = fdisp_pkg::K_WR;
        byte_c = {fdisp_pkg::MCODE_PREFIX, fdisp_pkg::MCODE_LOW};
      end
      4'h2: kind = fdisp_pkg::K_START;
      4'h3: begin
        kind   = fdisp_pkg::K_WR;
        byte_c = {fdisp_pkg::SLAVE_ADDR, 1'b0};
      end
      4'h4: begin
        kind   = fdisp_pkg::K_WR;
        byte_c = reg_q;
      end
      4'h5: begin
        kind   = rd_q ? fdisp_pkg::K_START : fdisp_pkg::K_WR;
        byte_c = dat_q;
      end
      4'h6: begin
        kind   = rd_q ? fdisp_pkg::K_WR : fdisp_pkg::K_STOP;
        byte_c = {fdisp_pkg::SLAVE_ADDR, 1'b1};
      end
      4'h7: kind = fdisp_pkg::K_RD;
      default: kind = fdisp_pkg::K_STOP;
    endcase
  end

  // quarter 0 low, 1 and 2 high, 3 low except in a stop; bits move in quarter 0, start and stop in quarter 2
  always_comb begin
    scl_c = (qtr_q == 2'h1) || (qtr_q == 2'h2);
    sda_c = 1'b1;
    unique case (kind)
      fdisp_pkg::K_START: sda_c = qtr_q < 2'h2;
      fdisp_pkg::K_STOP: begin
        sda_c = qtr_q >= 2'h2;
        scl_c = qtr_q != 2'h0;
      end
      fdisp_pkg::K_WR: begin
        if (bit_q != fdisp_pkg::BIT_ACK) begin
          sda_c = byte_c[3'(fdisp_pkg::BIT_LAST_TX - bit_q)];
        end
      end
      fdisp_pkg::K_RD: sda_c = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sy1_q <= 1'b1;
      sy2_q <= 1'b1;
      sy3_q <= 1'b1;
      sf_q  <= 1'b1;
    end else begin
      sy1_q <= bus.sda;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      if (sy2_q == sy3_q) begin
        sf_q <= sy2_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state_q == fdisp_pkg::HOST_IDLE) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_c;
      sda_q <= sda_c;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || tick) begin
      div_q <= (fast_q ? fdisp_pkg::HS_QTR_CYC
                       : fdisp_pkg::FS_QTR_CYC) - 6'h01;
    end else begin
      div_q <= div_q - 6'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= fdisp_pkg::HOST_IDLE;
      idx_q   <= fdisp_pkg::STEP_LS_FIRST;
      bit_q   <= '0;
      qtr_q   <= '0;
      rd_q    <= 1'b0;
      hs_q    <= 1'b0;
      fast_q  <= 1'b0;
      reg_q   <= '0;
      dat_q   <= '0;
      sh_q    <= '0;
      ack_q   <= 1'b0;
      ok_q    <= 1'b0;
      rsp_q   <= 1'b0;
      rsp_data_o <= '0;
    end else begin
      rsp_q <= 1'b0;
      unique case (state_q)
        fdisp_pkg::HOST_IDLE: begin
          if (cmd_valid_i) begin
            state_q <= fdisp_pkg::HOST_RUN;
            idx_q   <= cmd_hs_i ? fdisp_pkg::STEP_HS_FIRST
                                : fdisp_pkg::STEP_LS_FIRST;
            bit_q   <= '0;
            qtr_q   <= '0;
            rd_q    <= cmd_rd_i;
            hs_q    <= cmd_hs_i;
            reg_q   <= cmd_reg_i;
            dat_q   <= cmd_data_i;
            ok_q    <= 1'b1;
          end
        end
        fdisp_pkg::HOST_RUN: begin
          // high speed only after the restart that follows the code
          fast_q <= hs_q && idx_q >= fdisp_pkg::STEP_HS_FROM;
          if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            if (qtr_q == 2'h2) begin
              if (kind == fdisp_pkg::K_WR && bit_q == fdisp_pkg::BIT_ACK) begin
                ack_q <= !sf_q;
              end
              if (kind == fdisp_pkg::K_RD && bit_q != fdisp_pkg::BIT_ACK) begin
                sh_q <= {sh_q[6:0], sf_q};
              end
            end
            if (qtr_q == 2'h3) begin
              bit_q <= bit_q + 4'h1;
              if (kind == fdisp_pkg::K_STOP) begin
                state_q    <= fdisp_pkg::HOST_IDLE;
                fast_q     <= 1'b0;
                rsp_q      <= 1'b1;
                rsp_data_o <= sh_q;
              end else if (kind == fdisp_pkg::K_START) begin
                idx_q <= idx_q + 4'h1;
                bit_q <= '0;
              end else if (bit_q == fdisp_pkg::BIT_ACK) begin
                bit_q <= '0;
                idx_q <= idx_q + 4'h1;
                // the master code is never acknowledged
                if (kind == fdisp_pkg::K_WR && !ack_q && idx_q != 4'h1) begin
                  ok_q  <= 1'b0;
                  idx_q <= fdisp_pkg::STEP_STOP;
                end
              end
            end
          end
        end
      endcase
    end
  end
endmodule

/* dv/fdisp_assertions.sv */
// Purpose: wire checks on the bus joining host end and device end
// Assumes: one clock domain; rst_i synchronous, active high
// Notes:   bit count restarts at every start, so only address acks are judged
`timescale 1ns/1ps
module fdisp_assertions (
  input logic clk_sys_i,
  input logic rst_i,
  input logic h_scl_o,
  input logic h_scl_oe,
  input logic h_sda_o,
  input logic h_sda_oe,
  input logic d_scl_o,
  input logic d_scl_oe,
  input logic d_sda_o,
  input logic d_sda_oe,
  input logic scl,
  input logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] tot_q;
  logic [7:0] adr_q;
  logic       cond_w;
  logic       start_w;

  assign start_w = scl_q && scl && sda_q && !sda;
  assign cond_w  = scl_q && scl && (sda_q != sda);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // saturates so a stray edge after stop is never mistaken for an ack
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tot_q <= 4'hf;
    end else if (start_w) begin
      tot_q <= 4'h0;
    end else if (scl && !scl_q && tot_q != 4'hf) begin
      tot_q <= tot_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (scl && !scl_q && tot_q < 4'h8) begin
      adr_q <= {adr_q[6:0], sda};
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet;
    !d_sda_oe [*8];
  endsequence
  sequence s_ack_end;
    $fell(scl) && tot_q == 4'h9;
  endsequence

  property p_dev_no_clk;
    !d_scl_oe && !d_scl_o;
  endproperty
  property p_dev_od;
    d_sda_oe |-> !d_sda_o;
  endproperty
  property p_host_od;
    !(h_scl_oe && h_scl_o) && !(h_sda_oe && h_sda_o);
  endproperty
  property p_dev_hold;
    $changed(d_sda_oe) |-> !scl;
  endproperty
  property p_addr_quiet;
    scl && !scl_q && tot_q < 4'h8 |-> !d_sda_oe;
  endproperty
  property p_addr_ack;
    s_ack_end |-> adr_q[7:1] != fdisp_pkg::SLAVE_ADDR || d_sda_oe;
  endproperty
  property p_addr_ign;
    s_ack_end |-> adr_q[7:1] == fdisp_pkg::SLAVE_ADDR || !d_sda_oe;
  endproperty
  property p_cond_quiet;
    cond_w |=> s_quiet;
  endproperty

  a_dev_no_clk: assert property (p_dev_no_clk)
    else $error("device drove the clock line");
  a_dev_od: assert property (p_dev_od)
    else $error("device drove data high");
  a_host_od: assert property (p_host_od)
    else $error("host drove a line high");
  a_dev_hold: assert property (p_dev_hold)
    else $error("device changed data while clock high");
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("device drove data during address bits");
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  a_addr_ign: assert property (p_addr_ign)
    else $error("foreign address or master code acknowledged");
  a_cond_quiet: assert property (p_cond_quiet)
    else $error("device drove data right after start or stop");
endmodule

/* dv/fdisp_tb.sv */
// Purpose: bench for host end and device end of the two-wire port
// Assumes: 50 MHz clock; second bus bit-banged at the fast-mode quarter
// Notes:   second bus carries addresses the host end can never produce
`timescale 1ns/1ps
module fdisp_tb;
  logic       clk_sys_i;
  logic       rst_i;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_rd;
  logic       cmd_hs;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic       rsp_ack;
  logic [7:0] rsp_data;
  logic       hs_h;
  logic       hs_d;
  logic       hs_seen;
  logic       wr_ready;
  logic       wr_valid;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_valid2;
  logic [7:0] wr_addr2;
  logic [7:0] wr_data2;
  logic [7:0] rd_addr;
  logic [7:0] rd_addr2;
  logic [7:0] rd_data;
  logic       rd_hit;
  int         bad_count;
  int         check_count;
  int         cyc;

  fdisp_if b1 ();
  fdisp_if b2 ();

  fdisp_host i_fdisp_host (.clk_sys_i, .rst_i, .bus(b1.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_rd_i(cmd_rd),
    .cmd_hs_i(cmd_hs), .cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data),
    .rsp_valid_o(rsp_valid), .rsp_ack_o(rsp_ack), .rsp_data_o(rsp_data),
    .hs_mode_o(hs_h));
  fdisp_dev i_fdisp_dev (.clk_sys_i, .rst_i, .bus(b1.dev),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .rd_hit_i(rd_hit), .hs_mode_o(hs_d));
  fdisp_dev i_fdisp_dev_2 (.clk_sys_i, .rst_i, .bus(b2.dev),
    .wr_valid_o(wr_valid2), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr2),
    .wr_data_o(wr_data2), .rd_addr_o(rd_addr2),
    .rd_data_i(rd_addr2 ^ 8'h5a), .rd_hit_i(rd_addr2 < 8'h10),
    .hs_mode_o());
  fdisp_assertions i_fdisp_assertions (.clk_sys_i, .rst_i,
    .h_scl_o(b1.h_scl_o), .h_scl_oe(b1.h_scl_oe), .h_sda_o(b1.h_sda_o),
    .h_sda_oe(b1.h_sda_oe), .d_scl_o(b1.d_scl_o), .d_scl_oe(b1.d_scl_oe),
    .d_sda_o(b1.d_sda_o), .d_sda_oe(b1.d_sda_oe), .scl(b1.scl),
    .sda(b1.sda));

  // low addresses exist, the rest read as absent
  assign rd_hit  = rd_addr < 8'h10;
  assign rd_data = rd_addr ^ 8'h5a;

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (hs_h === 1'b1 && hs_d === 1'b1) hs_seen <= 1'b1;
    if (cyc == 90000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // one command, returns once the response pulse has been seen
  task automatic cmd(input logic rd, input logic hs, input logic [7:0] r,
                     input logic [7:0] d);
    @(negedge clk_sys_i);
    cmd_rd = rd;
    cmd_hs = hs;
    cmd_reg = r;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk_sys_i);
    while (cmd_ready !== 1'b1) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1) @(negedge clk_sys_i);
  endtask

  task automatic q(input logic c, input logic d);
    b2.h_scl_oe = !c;
    b2.h_sda_oe = !d;
    repeat (32) @(negedge clk_sys_i);
  endtask

  task automatic bb_byte(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      q(1'b0, b[i]);
      q(1'b1, b[i]);
      q(1'b1, b[i]);
      q(1'b0, b[i]);
    end
    q(1'b0, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b1);
    chk({15'h0, b2.sda}, {15'h0, !ack});
    q(1'b0, 1'b1);
  endtask

  // master side of a read byte: data sampled mid high phase
  task automatic bb_rd(input logic [7:0] exp, input logic mack);
    logic [7:0] got;
    for (int i = 7; i >= 0; i--) begin
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
      got[i] = b2.sda;
      q(1'b1, 1'b1);
      q(1'b0, 1'b1);
    end
    q(1'b0, !mack);
    q(1'b1, !mack);
    q(1'b1, !mack);
    q(1'b0, !mack);
    chk({8'h0, got}, {8'h0, exp});
  endtask

  task automatic t_fill();
    wr_ready = 1'b0;
    for (int i = 0; i < 5; i++) begin
      cmd(1'b0, 1'b0, 8'h05 + i[7:0], 8'ha5 + i[7:0]);
      chk({15'h0, rsp_ack}, {15'h0, 1'(i < 4)});
      chk({wr_addr, wr_data}, 16'h05a5);
    end
    wr_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk({wr_addr, wr_data}, {8'h05 + i[7:0], 8'ha5 + i[7:0]});
      @(negedge clk_sys_i);
    end
    chk({15'h0, wr_valid}, 16'h0);
  endtask

  task automatic t_read();
    cmd(1'b1, 1'b0, 8'h03, 8'h00);
    chk({7'h0, rsp_ack, rsp_data}, 16'h0159);
    cmd(1'b1, 1'b0, 8'h40, 8'h00);
    chk({7'h0, rsp_ack, rsp_data}, 16'h0100);
  endtask

  task automatic t_hs();
    hs_seen = 1'b0;
    cmd(1'b0, 1'b1, 8'h0a, 8'h11);
    chk({15'h0, rsp_ack}, 16'h1);
    chk({15'h0, hs_seen}, 16'h1);
    @(negedge clk_sys_i);
    chk({14'h0, hs_h, hs_d}, 16'h0);
    cmd(1'b0, 1'b0, 8'h0b, 8'h22);
    chk({15'h0, rsp_ack}, 16'h1);
  endtask

  // foreign, general call, 10-bit, master code, neighbour read
  task automatic t_bus2();
    logic [7:0] bad [5];
    bad = '{8'h68, 8'h00, 8'hf0, 8'h0b, 8'h65};
    foreach (bad[i]) begin
      q(1'b1, 1'b0);
      q(1'b0, 1'b0);
      bb_byte(bad[i], 1'b0);
      q(1'b0, 1'b0);
      q(1'b1, 1'b0);
      q(1'b1, 1'b1);
    end
    wr_ready = 1'b0;
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
    bb_byte(8'h66, 1'b1);
    bb_byte(8'h07, 1'b1);
    chk({15'h0, wr_valid2}, 16'h0);
    bb_byte(8'h3c, 1'b1);
    bb_byte(8'h3d, 1'b1);
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
    chk({7'h0, wr_valid2, wr_addr2}, 16'h0107);
    chk({8'h0, wr_data2}, 16'h003c);
    wr_ready = 1'b1;
    @(negedge clk_sys_i);
    chk({wr_addr2, wr_data2}, 16'h083d);
    @(negedge clk_sys_i);
    chk({15'h0, wr_valid2}, 16'h0);
  endtask

  // read on the second bus: first byte acked by master, second refused
  task automatic t_rd2();
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
    bb_byte(8'h66, 1'b1);
    bb_byte(8'h02, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
    bb_byte(8'h67, 1'b1);
    bb_rd(8'h58, 1'b1);
    bb_rd(8'h59, 1'b0);
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
  endtask

  initial begin
    rst_i = 1'b1;
    cmd_valid = 1'b0;
    cmd_rd = 1'b0;
    cmd_hs = 1'b0;
    cmd_reg = 8'h00;
    cmd_data = 8'h00;
    wr_ready = 1'b1;
    hs_seen = 1'b0;
    b2.h_scl_o = 1'b0;
    b2.h_sda_o = 1'b0;
    b2.h_scl_oe = 1'b0;
    b2.h_sda_oe = 1'b0;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk({10'h0, cmd_ready, wr_valid, b1.scl, b1.sda, hs_h, hs_d},
        16'h002c);
    t_fill();
    t_read();
    t_hs();
    t_bus2();
    t_rd2();
    summarize();
  end
endmodule
